// ### mie_defs.svh
`ifndef MIE_DEFS_SVH
`define MIE_DEFS_SVH

// Timing nibbles: {bin bytes, bin states, src bytes, src states}
`define MIE_T_LD_UPPER  16'h5342
`define MIE_T_SEXT      16'h3221
`define MIE_T_ZEXT      16'h3221
`define MIE_T_CODE_DP   16'h1616
`define MIE_T_CODE_PC   16'h1616
`define MIE_T_XRD_PTR   16'h1415
`define MIE_T_XRD_DP    16'h1313
`define MIE_T_XWR_PTR   16'h1414
`define MIE_T_XWR_DP    16'h1414
`define MIE_T_AR_BANK   16'h1122
`define MIE_T_AR_DIR    16'h2121
`define MIE_T_AR_IND    16'h1223
`define MIE_T_AR_IMM    16'h2121
`define MIE_T_BANK_AR   16'h1122
`define MIE_T_BANK_DIR  16'h2132
`define MIE_T_BANK_IMM  16'h2132
`define MIE_T_DIR_AR    16'h2222
`define MIE_T_DIR_BANK  16'h2233
`define MIE_T_DIR_DIR   16'h3333
`define MIE_T_DIR_IND   16'h2334
`define MIE_T_DIR_IMM   16'h3333
`define MIE_T_IND_AR    16'h1324
`define MIE_T_IND_DIR   16'h2334
`define MIE_T_IND_IMM   16'h2334
`define MIE_T_DP_IMM    16'h3232

// Extra states
`define MIE_PEN_PORT    5'h01
`define MIE_PEN_PERIPH  5'h02
`define MIE_EXT_ADD1    5'h01
`define MIE_EXT_ADD2    5'h02

`define MIE_REGION_RST  8'h01

`endif

// ### mie_pkg.sv
package mie_pkg;

  typedef enum logic [4:0] {
    OP_LD_UPPER, OP_SEXT, OP_ZEXT, OP_CODE_DP, OP_CODE_PC,
    OP_XRD_PTR, OP_XRD_DP, OP_XWR_PTR, OP_XWR_DP,
    OP_AR_BANK, OP_AR_DIR, OP_AR_IND, OP_AR_IMM,
    OP_BANK_AR, OP_BANK_DIR, OP_BANK_IMM,
    OP_DIR_AR, OP_DIR_BANK, OP_DIR_DIR, OP_DIR_IND, OP_DIR_IMM,
    OP_IND_AR, OP_IND_DIR, OP_IND_IMM, OP_DP_IMM
  } mie_op_type;

  typedef enum logic [1:0] {
    SP_CODE, SP_XDATA, SP_IDATA, SP_DIRECT
  } mie_space_type;

  typedef enum logic [2:0] {
    DST_NONE, DST_ACCUM, DST_BANK, DST_WORD, DST_DWORD, DST_DATA_PTR
  } mie_dst_type;

  typedef enum logic [1:0] {
    DK_RAM, DK_PORT, DK_PERIPH
  } mie_dirk_type;

  typedef enum logic [1:0] {
    WS_ACCUM, WS_BYTE, WS_IMM, WS_READ
  } mie_wsel_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_SPARE = 3'b100
  } mie_state_type;

  typedef struct packed {
    logic [15:0] imm16;
    logic [7:0]  accum;
    logic [7:0]  src_byte;
    logic [7:0]  ind_ptr;
    logic [7:0]  dir_src;
    logic [7:0]  dir_dst;
    logic [15:0] data_ptr;
    logic [15:0] pc;
    logic [31:0] dword;
  } mie_opnd_type;

  typedef struct packed {
    logic          rd;
    mie_space_type rd_sp;
    logic          wr;
    mie_space_type wr_sp;
    mie_dst_type   dst;
    mie_wsel_type  wsel;
    logic          dsrc;
    logic          ddst;
  } mie_dec_type;

  typedef struct packed {
    mie_dst_type dst;
    logic [31:0] data;
  } mie_res_type;

endpackage : mie_pkg

// ### mie_move_exec.sv
`timescale 1ns/100ps
`include "mie_defs.svh"

module mie_move_exec (
  input  wire logic                 core_clk_in,     // Core clock
  input  wire logic                 sys_rst_in,      // Sync reset, high
  input  wire logic                 start_in,        // Issue request
  input  wire mie_pkg::mie_op_type  op_in,           // Decoded move op
  input  wire logic                 src_mode_in,     // 1 = source mode
  input  wire mie_pkg::mie_opnd_type opnd_in,        // Operand values
  input  wire logic                 ext_in,          // Target is external
  input  wire logic [2:0]           wait_n_in,       // Wait states N
  input  wire mie_pkg::mie_dirk_type dsrc_kind_in,   // Source direct kind
  input  wire mie_pkg::mie_dirk_type ddst_kind_in,   // Dest direct kind
  input  wire logic                 region_wr_in,    // Region selector load
  input  wire logic [7:0]           region_data_in,  // Region selector value
  input  wire logic [7:0]           mem_rdata_in,    // Same-cycle read data
  output logic                      ready_out,       // Can take issue
  output logic                      busy_out,        // Instruction in states
  output logic                      done_out,        // Result valid pulse
  output mie_pkg::mie_res_type      res_out,         // Write-back
  output logic [3:0]                len_out,         // Instruction bytes
  output logic                      mem_req_out,     // Memory access
  output logic                      mem_we_out,      // Access is write
  output mie_pkg::mie_space_type    mem_space_out,   // Access space
  output logic [23:0]               mem_addr_out,    // Access address
  output logic [7:0]                mem_wdata_out,   // Write data
  output logic [7:0]                region_sel_out,  // Region selector
  output logic                      flags_we_out     // Flag write, never
);

  mie_pkg::mie_state_type state_q;
  mie_pkg::mie_op_type    op_q;
  mie_pkg::mie_opnd_type  opnd_q;
  mie_pkg::mie_dec_type   dec_d;
  mie_pkg::mie_dec_type   dec_q;
  mie_pkg::mie_res_type   res_d;
  mie_pkg::mie_res_type   res_q;
  mie_pkg::mie_space_type space_q;
  mie_pkg::mie_dirk_type  dsk_q;
  mie_pkg::mie_dirk_type  ddk_q;
  logic [15:0]            ent;
  logic [4:0]             base_d;
  logic [4:0]             pen_d;
  logic [4:0]             rem_q;
  logic [4:0]             bcnt_q;
  logic [23:0]            raddr_d;
  logic [23:0]            waddr_d;
  logic [23:0]            waddr_q;
  logic [23:0]            addr_q;
  logic [7:0]             wdata_d;
  logic [7:0]             wdata_q;
  logic [7:0]             rd_q;
  logic [7:0]             rd_val;
  logic [7:0]             region_q;
  logic [3:0]             len_q;
  logic [2:0]             n_q;
  logic                   first_q;
  logic                   ext_q;
  logic                   done_q;
  logic                   take;
  logic                   run;
  logic                   last;

  function automatic logic [4:0] dir_pen(input mie_pkg::mie_dirk_type k);
    case (k)
      mie_pkg::DK_PORT:   dir_pen = `MIE_PEN_PORT;
      mie_pkg::DK_PERIPH: dir_pen = `MIE_PEN_PERIPH;
      default:            dir_pen = 5'h00;
    endcase
  endfunction : dir_pen

  assign run  = (state_q == mie_pkg::ST_RUN);
  assign take = (state_q == mie_pkg::ST_IDLE) && start_in;
  assign last = run && (rem_q == 5'h01);

  // Timing table
  always_comb begin
    case (op_in)
      mie_pkg::OP_LD_UPPER: ent = `MIE_T_LD_UPPER;
      mie_pkg::OP_SEXT:     ent = `MIE_T_SEXT;
      mie_pkg::OP_ZEXT:     ent = `MIE_T_ZEXT;
      mie_pkg::OP_CODE_DP:  ent = `MIE_T_CODE_DP;
      mie_pkg::OP_CODE_PC:  ent = `MIE_T_CODE_PC;
      mie_pkg::OP_XRD_PTR:  ent = `MIE_T_XRD_PTR;
      mie_pkg::OP_XRD_DP:   ent = `MIE_T_XRD_DP;
      mie_pkg::OP_XWR_PTR:  ent = `MIE_T_XWR_PTR;
      mie_pkg::OP_XWR_DP:   ent = `MIE_T_XWR_DP;
      mie_pkg::OP_AR_BANK:  ent = `MIE_T_AR_BANK;
      mie_pkg::OP_AR_DIR:   ent = `MIE_T_AR_DIR;
      mie_pkg::OP_AR_IND:   ent = `MIE_T_AR_IND;
      mie_pkg::OP_AR_IMM:   ent = `MIE_T_AR_IMM;
      mie_pkg::OP_BANK_AR:  ent = `MIE_T_BANK_AR;
      mie_pkg::OP_BANK_DIR: ent = `MIE_T_BANK_DIR;
      mie_pkg::OP_BANK_IMM: ent = `MIE_T_BANK_IMM;
      mie_pkg::OP_DIR_AR:   ent = `MIE_T_DIR_AR;
      mie_pkg::OP_DIR_BANK: ent = `MIE_T_DIR_BANK;
      mie_pkg::OP_DIR_DIR:  ent = `MIE_T_DIR_DIR;
      mie_pkg::OP_DIR_IND:  ent = `MIE_T_DIR_IND;
      mie_pkg::OP_DIR_IMM:  ent = `MIE_T_DIR_IMM;
      mie_pkg::OP_IND_AR:   ent = `MIE_T_IND_AR;
      mie_pkg::OP_IND_DIR:  ent = `MIE_T_IND_DIR;
      mie_pkg::OP_IND_IMM:  ent = `MIE_T_IND_IMM;
      mie_pkg::OP_DP_IMM:   ent = `MIE_T_DP_IMM;
      default:              ent = 16'h0000;
    endcase
  end

  assign base_d = {1'b0, src_mode_in ? ent[3:0] : ent[11:8]};

  // Access decode
  always_comb begin
    dec_d = '0;
    case (op_in)
      mie_pkg::OP_LD_UPPER: dec_d.dst = mie_pkg::DST_DWORD;
      mie_pkg::OP_SEXT,
      mie_pkg::OP_ZEXT:     dec_d.dst = mie_pkg::DST_WORD;
      mie_pkg::OP_CODE_DP,
      mie_pkg::OP_CODE_PC: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_CODE;
        dec_d.dst   = mie_pkg::DST_ACCUM;
      end
      mie_pkg::OP_XRD_PTR,
      mie_pkg::OP_XRD_DP: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_XDATA;
        dec_d.dst   = mie_pkg::DST_ACCUM;
      end
      mie_pkg::OP_XWR_PTR,
      mie_pkg::OP_XWR_DP: begin
        dec_d.wr    = 1'b1;
        dec_d.wr_sp = mie_pkg::SP_XDATA;
      end
      mie_pkg::OP_AR_BANK,
      mie_pkg::OP_AR_IMM:   dec_d.dst = mie_pkg::DST_ACCUM;
      mie_pkg::OP_AR_DIR: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_DIRECT;
        dec_d.dsrc  = 1'b1;
        dec_d.dst   = mie_pkg::DST_ACCUM;
      end
      mie_pkg::OP_AR_IND: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_IDATA;
        dec_d.dst   = mie_pkg::DST_ACCUM;
      end
      mie_pkg::OP_BANK_AR,
      mie_pkg::OP_BANK_IMM: dec_d.dst = mie_pkg::DST_BANK;
      mie_pkg::OP_BANK_DIR: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_DIRECT;
        dec_d.dsrc  = 1'b1;
        dec_d.dst   = mie_pkg::DST_BANK;
      end
      mie_pkg::OP_DIR_AR,
      mie_pkg::OP_DIR_BANK,
      mie_pkg::OP_DIR_IMM: begin
        dec_d.wr    = 1'b1;
        dec_d.wr_sp = mie_pkg::SP_DIRECT;
        dec_d.ddst  = 1'b1;
      end
      mie_pkg::OP_DIR_DIR,
      mie_pkg::OP_DIR_IND: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = (op_in == mie_pkg::OP_DIR_DIR) ? mie_pkg::SP_DIRECT : mie_pkg::SP_IDATA;
        dec_d.dsrc  = (op_in == mie_pkg::OP_DIR_DIR);
        dec_d.wr    = 1'b1;
        dec_d.wr_sp = mie_pkg::SP_DIRECT;
        dec_d.ddst  = 1'b1;
      end
      mie_pkg::OP_IND_AR,
      mie_pkg::OP_IND_IMM: begin
        dec_d.wr    = 1'b1;
        dec_d.wr_sp = mie_pkg::SP_IDATA;
      end
      mie_pkg::OP_IND_DIR: begin
        dec_d.rd    = 1'b1;
        dec_d.rd_sp = mie_pkg::SP_DIRECT;
        dec_d.dsrc  = 1'b1;
        dec_d.wr    = 1'b1;
        dec_d.wr_sp = mie_pkg::SP_IDATA;
      end
      mie_pkg::OP_DP_IMM:   dec_d.dst = mie_pkg::DST_DATA_PTR;
      default:              dec_d = '0;
    endcase
    case (op_in)
      mie_pkg::OP_DIR_BANK: dec_d.wsel = mie_pkg::WS_BYTE;
      mie_pkg::OP_DIR_IMM,
      mie_pkg::OP_IND_IMM:  dec_d.wsel = mie_pkg::WS_IMM;
      mie_pkg::OP_DIR_DIR,
      mie_pkg::OP_DIR_IND,
      mie_pkg::OP_IND_DIR:  dec_d.wsel = mie_pkg::WS_READ;
      default:              dec_d.wsel = mie_pkg::WS_ACCUM;
    endcase
  end

  // Extra states for external and direct operands
  always_comb begin
    pen_d = 5'h00;
    if (ext_in) begin
      case (op_in)
        mie_pkg::OP_CODE_DP,
        mie_pkg::OP_CODE_PC,
        mie_pkg::OP_XWR_DP: pen_d = {2'b00, wait_n_in} + `MIE_EXT_ADD1;
        mie_pkg::OP_XRD_DP: pen_d = {2'b00, wait_n_in} + `MIE_EXT_ADD2;
        default:            pen_d = 5'h00;
      endcase
    end
    if (dec_d.dsrc)
      pen_d = pen_d + dir_pen(dsrc_kind_in);
    if (dec_d.ddst)
      pen_d = pen_d + dir_pen(ddst_kind_in);
  end

  // Addresses, extended space inside the selected region
  always_comb begin
    raddr_d = {16'h0000, opnd_in.dir_src};
    waddr_d = {16'h0000, opnd_in.dir_dst};
    case (op_in)
      mie_pkg::OP_CODE_DP: raddr_d = {8'h00, opnd_in.data_ptr + {8'h00, opnd_in.accum}};
      mie_pkg::OP_CODE_PC: raddr_d = {8'h00, opnd_in.pc + {8'h00, opnd_in.accum}};
      mie_pkg::OP_XRD_PTR: raddr_d = {region_q, 8'h00, opnd_in.ind_ptr};
      mie_pkg::OP_XRD_DP:  raddr_d = {region_q, opnd_in.data_ptr};
      mie_pkg::OP_XWR_PTR: waddr_d = {region_q, 8'h00, opnd_in.ind_ptr};
      mie_pkg::OP_XWR_DP:  waddr_d = {region_q, opnd_in.data_ptr};
      mie_pkg::OP_AR_IND,
      mie_pkg::OP_DIR_IND: raddr_d = {16'h0000, opnd_in.ind_ptr};
      mie_pkg::OP_IND_AR,
      mie_pkg::OP_IND_DIR,
      mie_pkg::OP_IND_IMM: waddr_d = {16'h0000, opnd_in.ind_ptr};
      default:             raddr_d = {16'h0000, opnd_in.dir_src};
    endcase
    case (dec_d.wsel)
      mie_pkg::WS_BYTE: wdata_d = opnd_in.src_byte;
      mie_pkg::WS_IMM:  wdata_d = opnd_in.imm16[7:0];
      default:          wdata_d = opnd_in.accum;
    endcase
  end

  // Sequencer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= mie_pkg::ST_IDLE;
      rem_q   <= 5'h00;
      first_q <= 1'b0;
    end else begin
      case (state_q)
        mie_pkg::ST_IDLE: begin
          if (start_in) begin
            state_q <= mie_pkg::ST_RUN;
            rem_q   <= base_d + pen_d;
            first_q <= 1'b1;
          end
        end
        mie_pkg::ST_RUN: begin
          first_q <= 1'b0;
          rem_q   <= rem_q - 5'h01;
          if (rem_q == 5'h01)
            state_q <= mie_pkg::ST_IDLE;
        end
        default: state_q <= mie_pkg::ST_IDLE;
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      op_q   <= mie_pkg::OP_LD_UPPER;
      opnd_q <= '0;
      dec_q  <= '0;
      ext_q  <= 1'b0;
      n_q    <= 3'h0;
      dsk_q  <= mie_pkg::DK_RAM;
      ddk_q  <= mie_pkg::DK_RAM;
      len_q  <= 4'h0;
    end else if (take) begin
      op_q   <= op_in;
      opnd_q <= opnd_in;
      dec_q  <= dec_d;
      ext_q  <= ext_in;
      n_q    <= wait_n_in;
      dsk_q  <= dsrc_kind_in;
      ddk_q  <= ddst_kind_in;
      len_q  <= src_mode_in ? ent[7:4] : ent[15:12];
    end
  end

  // Memory side: read in first state, write in last
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      addr_q  <= 24'h000000;
      waddr_q <= 24'h000000;
      space_q <= mie_pkg::SP_CODE;
      wdata_q <= 8'h00;
      rd_q    <= 8'h00;
    end else if (take) begin
      addr_q  <= dec_d.rd ? raddr_d : waddr_d;
      waddr_q <= waddr_d;
      space_q <= dec_d.rd ? dec_d.rd_sp : dec_d.wr_sp;
      wdata_q <= wdata_d;
    end else if (run && first_q && dec_q.rd) begin
      rd_q <= mem_rdata_in;
      if (dec_q.wr) begin
        addr_q  <= waddr_q;
        space_q <= dec_q.wr_sp;
      end
      if (dec_q.wsel == mie_pkg::WS_READ)
        wdata_q <= mem_rdata_in;
    end
  end

  assign rd_val = first_q ? mem_rdata_in : rd_q;

  // Write-back value
  always_comb begin
    res_d.dst  = dec_q.dst;
    res_d.data = {24'h000000, rd_val};
    case (op_q)
      mie_pkg::OP_LD_UPPER: res_d.data = {opnd_q.imm16, opnd_q.dword[15:0]};
      mie_pkg::OP_SEXT:     res_d.data = {16'h0000, {8{opnd_q.src_byte[7]}}, opnd_q.src_byte};
      mie_pkg::OP_ZEXT:     res_d.data = {24'h000000, opnd_q.src_byte};
      mie_pkg::OP_AR_BANK:  res_d.data = {24'h000000, opnd_q.src_byte};
      mie_pkg::OP_AR_IMM,
      mie_pkg::OP_BANK_IMM: res_d.data = {24'h000000, opnd_q.imm16[7:0]};
      mie_pkg::OP_BANK_AR:  res_d.data = {24'h000000, opnd_q.accum};
      mie_pkg::OP_DP_IMM:   res_d.data = {16'h0000, opnd_q.imm16};
      default:              res_d.data = {24'h000000, rd_val};
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      res_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (last)
        res_q <= res_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in)
      region_q <= `MIE_REGION_RST;
    else if (region_wr_in)
      region_q <= region_data_in;
  end

  // Busy state count, read by checks
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in)
      bcnt_q <= 5'h00;
    else if (take)
      bcnt_q <= 5'h00;
    else if (run)
      bcnt_q <= bcnt_q + 5'h01;
  end

  assign ready_out      = (state_q == mie_pkg::ST_IDLE);
  assign busy_out       = run;
  assign done_out       = done_q;
  assign res_out        = res_q;
  assign len_out        = len_q;
  assign mem_req_out    = run && ((first_q && dec_q.rd) || (last && dec_q.wr));
  assign mem_we_out     = last && dec_q.wr;
  assign mem_space_out  = space_q;
  assign mem_addr_out   = addr_q;
  assign mem_wdata_out  = wdata_q;
  assign region_sel_out = region_q;
  assign flags_we_out   = 1'b0;

  property p_luw_time;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    take && op_in == mie_pkg::OP_LD_UPPER && !src_mode_in |=> busy_out [*3] ##1 done_out;
  endproperty
  a_luw_time: assert property (p_luw_time) else $error("upper load not 3 states");

  property p_luw_data;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && op_q == mie_pkg::OP_LD_UPPER |->
      res_out.data == {opnd_q.imm16, opnd_q.dword[15:0]} && res_out.dst == mie_pkg::DST_DWORD;
  endproperty
  a_luw_data: assert property (p_luw_data) else $error("upper load value wrong");

  property p_sext;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && op_q == mie_pkg::OP_SEXT |->
      res_out.data[15:0] == {{8{opnd_q.src_byte[7]}}, opnd_q.src_byte};
  endproperty
  a_sext: assert property (p_sext) else $error("sign extension wrong");

  property p_zext;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    take && op_in == mie_pkg::OP_ZEXT && src_mode_in |=> busy_out ##1 done_out && res_out.data[15:8] == 8'h00;
  endproperty
  a_zext: assert property (p_zext) else $error("zero extension wrong");

  property p_code_time;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    take && op_in == mie_pkg::OP_CODE_DP && !ext_in |=> busy_out [*6] ##1 (done_out && !busy_out);
  endproperty
  a_code_time: assert property (p_code_time) else $error("code read not 6 states");

  property p_xri_src;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    take && op_in == mie_pkg::OP_XRD_PTR && src_mode_in |=> busy_out [*5] ##1 done_out;
  endproperty
  a_xri_src: assert property (p_xri_src) else $error("pointer read not 5 states");

  property p_xrd_ext;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && op_q == mie_pkg::OP_XRD_DP && ext_q |-> bcnt_q == 5'h05 + {2'b00, n_q};
  endproperty
  a_xrd_ext: assert property (p_xrd_ext) else $error("external read count wrong");

  property p_xwr_ext;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && op_q == mie_pkg::OP_XWR_DP && ext_q |-> bcnt_q == 5'h05 + {2'b00, n_q};
  endproperty
  a_xwr_ext: assert property (p_xwr_ext) else $error("external write count wrong");

  property p_dirdir;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && op_q == mie_pkg::OP_DIR_DIR |-> bcnt_q == 5'h03 + dir_pen(dsk_q) + dir_pen(ddk_q);
  endproperty
  a_dirdir: assert property (p_dirdir) else $error("direct copy count wrong");

  property p_region;
    @(posedge core_clk_in) disable iff (sys_rst_in)
    mem_req_out && mem_space_out == mie_pkg::SP_XDATA |-> mem_addr_out[23:16] == $past(region_sel_out);
  endproperty
  a_region: assert property (p_region) else $error("extended access off region");

endmodule : mie_move_exec

// ### mie_mem_model.sv
`timescale 1ns/100ps
module mie_mem_model (
  input  wire logic        clk_in,    // Core clock
  input  wire logic        req_in,    // Access strobe
  input  wire logic        we_in,     // Access is write
  input  wire logic [23:0] addr_in,   // Address
  input  wire logic [7:0]  wdata_in,  // Write data
  output logic [7:0]       rdata_out, // Read data
  output logic [23:0]      raddr_out, // Last read address
  output logic [7:0]       wbyte_out  // Last written byte
);
  logic [7:0] last_q = 8'hA5;
  // Same-cycle answer; when idle show the inverse of the last byte
  assign rdata_out = (req_in && !we_in) ? (addr_in[7:0] ^ 8'h5A) : ~last_q;
  always_ff @(posedge clk_in) begin
    if (req_in && !we_in) begin
      raddr_out <= addr_in;
      last_q    <= addr_in[7:0] ^ 8'h5A;
    end
    if (req_in && we_in) wbyte_out <= wdata_in;
  end
endmodule : mie_mem_model

// ### move_instruction_exec_test.sv
`timescale 1ns/100ps
module move_instruction_exec_test;
  logic                   clk, rst, start, mode, ext, rwr, ready, busy, done, req, we, fwe;
  logic [2:0]             waitn;
  logic [3:0]             len;
  logic [7:0]             rdat, rdata, wdata, region, wbyte;
  logic [23:0]            addr, raddr;
  mie_pkg::mie_op_type    op;
  mie_pkg::mie_opnd_type  opnd;
  mie_pkg::mie_dirk_type  dks, dkd;
  mie_pkg::mie_res_type   res;
  mie_pkg::mie_space_type space;
  int                     n_fail, compares;

  mie_move_exec mie_move_exec_i (.core_clk_in(clk), .sys_rst_in(rst), .start_in(start), .op_in(op),
    .src_mode_in(mode), .opnd_in(opnd), .ext_in(ext), .wait_n_in(waitn), .dsrc_kind_in(dks),
    .ddst_kind_in(dkd), .region_wr_in(rwr), .region_data_in(rdat), .mem_rdata_in(rdata),
    .ready_out(ready), .busy_out(busy), .done_out(done), .res_out(res), .len_out(len),
    .mem_req_out(req), .mem_we_out(we), .mem_space_out(space), .mem_addr_out(addr),
    .mem_wdata_out(wdata), .region_sel_out(region), .flags_we_out(fwe));
  mie_mem_model mie_mem_model_i (.clk_in(clk), .req_in(req), .we_in(we), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata), .raddr_out(raddr), .wbyte_out(wbyte));

  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Issue one move and count edges from take to done
  task automatic issue(input mie_pkg::mie_op_type o, input logic m, input logic x, input logic [2:0] n,
                       input mie_pkg::mie_dirk_type s, input mie_pkg::mie_dirk_type d,
                       input mie_pkg::mie_opnd_type v, output int k);
    @(posedge clk);
    op    <= o;
    mode  <= m;
    ext   <= x;
    waitn <= n;
    dks   <= s;
    dkd   <= d;
    opnd  <= v;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (done !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_fail++;
      complete_run();
    end
  endtask : issue

  task automatic sc_upper;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.imm16 = 16'hBEEF;
    v.dword = 32'h12345678;
    issue(mie_pkg::OP_LD_UPPER, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("upper_states", k, 32'h3);
    check("upper_len", len, 32'h5);
    check("upper_data", res.data, 32'hBEEF5678);
    issue(mie_pkg::OP_LD_UPPER, 1'b1, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("upper_src_states", k, 32'h2);
    check("upper_src_len", len, 32'h4);
  endtask : sc_upper

  task automatic sc_extend;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.src_byte = 8'h80;
    issue(mie_pkg::OP_SEXT, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("sext_states", k, 32'h2);
    check("sext_data", res.data[15:0], 32'hFF80);
    issue(mie_pkg::OP_ZEXT, 1'b1, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("zext_states", k, 32'h1);
    check("zext_data", res.data[15:0], 32'h0080);
    check("flags_we", fwe, 32'h0);
  endtask : sc_extend

  task automatic sc_memory;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.accum = 8'h10;
    v.data_ptr = 16'h0100;
    issue(mie_pkg::OP_CODE_DP, 1'b0, 1'b1, 3'h2, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("code_states", k, 32'h9);
    check("code_addr", raddr[15:0], 32'h0110);
    check("code_data", res.data[7:0], 32'h4A);
    @(posedge clk);
    rwr  <= 1'b1;
    rdat <= 8'h23;
    @(posedge clk);
    rwr <= 1'b0;
    v.data_ptr = 16'h4567;
    issue(mie_pkg::OP_XRD_DP, 1'b0, 1'b1, 3'h1, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("region", region, 32'h23);
    check("xrd_states", k, 32'h6);
    check("xrd_space", space, 32'h1);
    check("xrd_addr", raddr, 32'h234567);
    check("xrd_data", res.data[7:0], 32'h3D);
    issue(mie_pkg::OP_XWR_DP, 1'b1, 1'b1, 3'h1, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("xwr_states", k, 32'h6);
    check("xwr_data", wbyte, 32'h10);
  endtask : sc_memory

  task automatic sc_dirdir;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.dir_src = 8'h90;
    v.dir_dst = 8'hC0;
    issue(mie_pkg::OP_DIR_DIR, 1'b0, 1'b0, 3'h0, mie_pkg::DK_PORT, mie_pkg::DK_PERIPH, v, k);
    check("dirdir_states", k, 32'h6);
    check("dirdir_data", wbyte, 32'hCA);
  endtask : sc_dirdir

  // Internal code reads and 8-bit pointer extended accesses, region still 23h
  task automatic sc_internal;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.accum = 8'h10;
    v.pc = 16'h0200;
    v.ind_ptr = 8'h34;
    issue(mie_pkg::OP_CODE_PC, 1'b1, 1'b0, 3'h3, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("pc_states", k, 32'h6);
    check("pc_addr", raddr, 32'h000210);
    check("pc_len", len, 32'h1);
    issue(mie_pkg::OP_CODE_DP, 1'b1, 1'b0, 3'h3, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("dp_states", k, 32'h6);
    check("dp_addr", raddr, 32'h000010);
    issue(mie_pkg::OP_XRD_PTR, 1'b1, 1'b1, 3'h3, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("xri_states", k, 32'h5);
    check("xri_addr", raddr, 32'h230034);
    check("xri_data", res.data, 32'h6E);
    check("xri_space", space, 32'h1);
    v.accum = 8'h77;
    issue(mie_pkg::OP_XWR_PTR, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("xwp_states", k, 32'h4);
    check("xwp_data", wbyte, 32'h77);
    check("busy_idle", busy, 32'h0);
  endtask : sc_internal

  // Legacy copies with port and peripheral penalties
  task automatic sc_legacy;
    mie_pkg::mie_opnd_type v;
    int k;
    v = '0;
    v.accum = 8'h3C;
    v.dir_src = 8'h81;
    v.dir_dst = 8'h82;
    v.ind_ptr = 8'h45;
    v.imm16 = 16'h1234;
    issue(mie_pkg::OP_DIR_AR, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_PORT, v, k);
    check("dir_acc_states", k, 32'h3);
    check("dir_acc_data", wbyte, 32'h3C);
    issue(mie_pkg::OP_IND_IMM, 1'b1, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("ind_imm_states", k, 32'h4);
    check("ind_imm_data", wbyte, 32'h34);
    check("ind_imm_len", len, 32'h3);
    issue(mie_pkg::OP_IND_AR, 1'b1, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("ind_acc_states", k, 32'h4);
    check("ind_acc_data", wbyte, 32'h3C);
    issue(mie_pkg::OP_DIR_IMM, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_PERIPH, v, k);
    check("dir_imm_states", k, 32'h5);
    check("dir_imm_data", wbyte, 32'h34);
    issue(mie_pkg::OP_BANK_DIR, 1'b1, 1'b0, 3'h0, mie_pkg::DK_PERIPH, mie_pkg::DK_RAM, v, k);
    check("bank_dir_states", k, 32'h4);
    check("bank_dir_data", res.data, 32'hDB);
    check("bank_dir_len", len, 32'h3);
    issue(mie_pkg::OP_AR_IND, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("acc_ind_states", k, 32'h2);
    check("acc_ind_data", res.data, 32'h1F);
    issue(mie_pkg::OP_DP_IMM, 1'b0, 1'b0, 3'h0, mie_pkg::DK_RAM, mie_pkg::DK_RAM, v, k);
    check("dp_imm_states", k, 32'h2);
    check("dp_imm_data", res.data, 32'h1234);
    check("dp_imm_len", len, 32'h3);
  endtask : sc_legacy

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst, start, mode, ext, rwr, waitn, rdat} = '0;
    rst  = 1'b1;
    op   = mie_pkg::OP_LD_UPPER;
    opnd = '0;
    dks  = mie_pkg::DK_RAM;
    dkd  = mie_pkg::DK_RAM;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 check("region_reset", region, 32'h01);
    check("ready_reset", ready, 32'h1);
    sc_upper();
    sc_extend();
    sc_memory();
    sc_dirdir();
    sc_internal();
    sc_legacy();
    complete_run();
  end
endmodule : move_instruction_exec_test
